// ===== verilog/ldc_config_regs.sv
// Strobed register access and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Second register bits 6..5 pick 0, 2, 4 or 6 ns low-gray compensation.
// - With second register bit 4 clear, bits 3..1 pick 0 to 70 ns delta in 10 ns steps.
// - With bit 4 set, 80 ns is added so bits 3..1 pick 80 to 150 ns.
// - Third register holds an enable and three dark-screen levels used when serial input is 0.
// - Fourth register holds an enable and three displaying levels used when serial input is 1.
// - Fifth register bits 4..0 set the dead-time voltage when serial input is 1; zero is off.
// - Sixth register bit 0 set disables the memory clock, only while fifth bit 15 is set.
// - First register bits 12..8 choose 1 to 32 scan lines, reset 00011 meaning 4.
// - First register bit 7 chooses 14-bit gray at 0 and 13-bit gray at 1.
// - Gray values split into upper and lower parts, the upper spread over refreshes.
// - First register bit 6 enables the grayscale clock multiplier, off at reset.
module ldc_config_regs (
   input wire logic clk, // 10 MHz clock
   input wire logic rst_n, // asynchronous reset, active low
   input wire logic [2:0] addr, // register index
   input wire logic [15:0] wdata, // write data
   input wire logic wr, // write strobe
   input wire logic rd, // read strobe
   output logic [15:0] rdata, // read data, cycle after strobe
   input wire logic serial_data_input, // serial input pin
   input wire logic [15:0] gray_word, // received 16-bit gray word
   output logic [13:0] gray_value, // gray value in active depth
   output logic gray_word_error, // low padding bits not zero in 14-bit mode
   output ldc_pkg::ldc_ctrl_t ctrl, // decoded controls
   output logic driver_reset // one-shot driver reset pulse
);
   logic [15:0] first_config_register;
   logic [15:0] second_config_register;
   logic [15:0] dark_reg;
   logic [15:0] disp_reg;
   logic [15:0] detect_reg;
   logic [15:0] memclk_reg;
   logic sdi_meta;
   logic sdi_sync;
   logic [1:0] reset_count;
   ldc_pkg::ldc_comp_t comp;
   logic [4:0] dead_level;
   logic [7:0] low_gray_ns;
   logic [7:0] delta_ns;
   logic [3:0] msb_bits;
   logic [3:0] lsb_bits;

   function automatic logic hit(input logic [2:0] a, input logic [2:0] idx);
      return a == idx;
   endfunction

   // Pin input passes two flops before use.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sdi_meta <= 1'b0;
         sdi_sync <= 1'b0;
      end else begin
         sdi_meta <= serial_data_input;
         sdi_sync <= sdi_meta;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         first_config_register <= ldc_pkg::RST_FIRST;
      end else if (wr && hit(addr, ldc_pkg::ADDR_FIRST)) begin
         first_config_register <= wdata;
      end
   end

   // Reset bit is self clearing, so it is never stored.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         second_config_register <= ldc_pkg::RST_LOW_GRAY;
      end else if (wr && hit(addr, ldc_pkg::ADDR_LOW_GRAY)) begin
         second_config_register <= wdata & ~(16'h0001 << ldc_pkg::HWRST_BIT);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dark_reg <= ldc_pkg::RST_DARK;
         disp_reg <= ldc_pkg::RST_DISP;
      end else if (wr) begin
         if (hit(addr, ldc_pkg::ADDR_DARK)) begin
            dark_reg <= wdata;
         end
         if (hit(addr, ldc_pkg::ADDR_DISP)) begin
            disp_reg <= wdata;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         detect_reg <= ldc_pkg::RST_DETECT;
         memclk_reg <= ldc_pkg::RST_MEMCLK;
      end else if (wr) begin
         if (hit(addr, ldc_pkg::ADDR_DETECT)) begin
            detect_reg <= wdata & ldc_pkg::MASK_DETECT;
         end
         if (hit(addr, ldc_pkg::ADDR_MEMCLK)) begin
            memclk_reg <= wdata & ldc_pkg::MASK_MEMCLK;
         end
      end
   end

   // A short pulse lets downstream logic on slow paths see the reset.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reset_count <= 2'h0;
      end else if (wr && hit(addr, ldc_pkg::ADDR_LOW_GRAY) && wdata[ldc_pkg::HWRST_BIT]) begin
         reset_count <= 2'(ldc_pkg::RESET_PULSE_CYCLES);
      end else if (reset_count != 2'h0) begin
         reset_count <= reset_count - 2'h1;
      end
   end
   assign driver_reset = reset_count != 2'h0;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= 16'h0000;
      end else if (rd) begin
         unique case (addr)
            ldc_pkg::ADDR_FIRST: rdata <= first_config_register;
            ldc_pkg::ADDR_LOW_GRAY: rdata <= second_config_register;
            ldc_pkg::ADDR_DARK: rdata <= dark_reg;
            ldc_pkg::ADDR_DISP: rdata <= disp_reg;
            ldc_pkg::ADDR_DETECT: rdata <= detect_reg;
            ldc_pkg::ADDR_MEMCLK: rdata <= memclk_reg;
            ldc_pkg::ADDR_STATUS: rdata <= {13'h0000, driver_reset, ctrl.memclk_en, sdi_sync};
            default: rdata <= 16'h0000;
         endcase
      end else begin
         rdata <= 16'h0000;
      end
   end

   ldc_comp_select u_comp (
      .serial_data_input(sdi_sync),
      .dark_reg(dark_reg),
      .disp_reg(disp_reg),
      .detect_reg(detect_reg),
      .comp(comp),
      .dead_level(dead_level)
   );

   ldc_timing_decode u_timing (
      .low_gray_reg(second_config_register),
      .first_reg(first_config_register),
      .low_gray_ns(low_gray_ns),
      .delta_ns(delta_ns),
      .msb_bits(msb_bits),
      .lsb_bits(lsb_bits)
   );

   // 14-bit mode drops the two zero padding bits; 13-bit mode drops three.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         gray_value <= 14'h0000;
         gray_word_error <= 1'b0;
      end else if (first_config_register[ldc_pkg::GRAY13_BIT]) begin
         gray_value <= {1'b0, gray_word[15:3]};
         gray_word_error <= 1'b0;
      end else begin
         gray_value <= gray_word[15:2];
         gray_word_error <= gray_word[1:0] != 2'h0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl <= '0;
      end else begin
         ctrl.scan_lines <= first_config_register[ldc_pkg::SCAN_LSB +: 5];
         ctrl.gray13 <= first_config_register[ldc_pkg::GRAY13_BIT];
         ctrl.multiplier_en <= first_config_register[ldc_pkg::MULT_BIT];
         ctrl.low_gray_ns <= low_gray_ns;
         ctrl.delta_ns <= delta_ns;
         ctrl.comp <= comp;
         ctrl.dead_level <= dead_level;
         ctrl.open_thresh <= detect_reg[ldc_pkg::OPEN_LSB +: 3];
         ctrl.memclk_en <= !(detect_reg[ldc_pkg::MEMCLK_EN6_BIT]
                             && memclk_reg[ldc_pkg::MEMCLK_DIS_BIT]);
         ctrl.msb_bits <= msb_bits;
         ctrl.lsb_bits <= lsb_bits;
      end
   end
endmodule // ldc_config_regs
`default_nettype wire

// ===== verilog/ldc_pkg.sv
`default_nettype none
package ldc_pkg;
   // Register indices on the plain register port.
   localparam logic [2:0] ADDR_FIRST = 3'h0;
   localparam logic [2:0] ADDR_LOW_GRAY = 3'h1;
   localparam logic [2:0] ADDR_DARK = 3'h2;
   localparam logic [2:0] ADDR_DISP = 3'h3;
   localparam logic [2:0] ADDR_DETECT = 3'h4;
   localparam logic [2:0] ADDR_MEMCLK = 3'h5;
   localparam logic [2:0] ADDR_STATUS = 3'h6;
   // Reset values.
   localparam logic [15:0] RST_FIRST = 16'h033f;
   localparam logic [15:0] RST_LOW_GRAY = 16'h0000;
   localparam logic [15:0] RST_DARK = 16'h7fff;
   localparam logic [15:0] RST_DISP = 16'h7fff;
   localparam logic [15:0] RST_DETECT = 16'h001f;
   localparam logic [15:0] RST_MEMCLK = 16'h0000;
   // Field positions.
   localparam int SCAN_LSB = 8;
   localparam int GRAY13_BIT = 7;
   localparam int MULT_BIT = 6;
   localparam int LGC_LSB = 5;
   localparam int DELTA_HI_BIT = 4;
   localparam int DELTA_LSB = 1;
   localparam int HWRST_BIT = 0;
   localparam int COMP_EN_BIT = 15;
   localparam int LVL_A_LSB = 10;
   localparam int LVL_B_LSB = 5;
   localparam int LVL_C_LSB = 0;
   localparam int OPEN_LSB = 5;
   localparam int DEAD_LSB = 0;
   localparam int MEMCLK_EN6_BIT = 15;
   localparam int MEMCLK_DIS_BIT = 0;
   // Timing steps in nanoseconds.
   localparam logic [7:0] LGC_STEP_NS = 8'h02;
   localparam logic [7:0] DELTA_STEP_NS = 8'h0a;
   localparam logic [7:0] DELTA_HI_NS = 8'h50;
   // Register write mask: writable bits for the fifth and sixth registers.
   localparam logic [15:0] MASK_DETECT = 16'h8fff;
   localparam logic [15:0] MASK_MEMCLK = 16'h0001;
   localparam int RESET_PULSE_CYCLES = 2;

   typedef struct packed {
      logic enable;
      logic [4:0] level_a;
      logic [4:0] level_b;
      logic [4:0] level_c;
   } ldc_comp_t;

   typedef struct packed {
      logic [4:0] scan_lines;
      logic gray13;
      logic multiplier_en;
      logic [7:0] low_gray_ns;
      logic [7:0] delta_ns;
      ldc_comp_t comp;
      logic [4:0] dead_level;
      logic [2:0] open_thresh;
      logic memclk_en;
      logic [3:0] msb_bits;
      logic [3:0] lsb_bits;
   } ldc_ctrl_t;
endpackage
`default_nettype wire

// ===== verilog/ldc_comp_select.sv
`timescale 1ns/1ps
`default_nettype none
module ldc_comp_select (
   input wire logic serial_data_input, // synchronised serial input bit
   input wire logic [15:0] dark_reg, // dark-screen register
   input wire logic [15:0] disp_reg, // displaying register
   input wire logic [15:0] detect_reg, // dead-time register
   output ldc_pkg::ldc_comp_t comp, // active compensation set
   output logic [4:0] dead_level // dead-time level, zero when off
);
   function automatic ldc_pkg::ldc_comp_t unpack_comp(input logic [15:0] r);
      ldc_pkg::ldc_comp_t c;
      c.enable = r[ldc_pkg::COMP_EN_BIT];
      c.level_a = r[ldc_pkg::LVL_A_LSB +: 5];
      c.level_b = r[ldc_pkg::LVL_B_LSB +: 5];
      c.level_c = r[ldc_pkg::LVL_C_LSB +: 5];
      return c;
   endfunction

   always_comb begin
      if (serial_data_input) begin
         comp = unpack_comp(disp_reg);
         dead_level = detect_reg[ldc_pkg::DEAD_LSB +: 5];
      end else begin
         comp = unpack_comp(dark_reg);
         dead_level = 5'h00;
      end
   end
endmodule // ldc_comp_select
`default_nettype wire

// ===== verilog/ldc_timing_decode.sv
`timescale 1ns/1ps
`default_nettype none
module ldc_timing_decode (
   input wire logic [15:0] low_gray_reg, // second register
   input wire logic [15:0] first_reg, // first register
   output logic [7:0] low_gray_ns, // low-gray compensation in ns
   output logic [7:0] delta_ns, // delta time in ns
   output logic [3:0] msb_bits, // upper gray part width
   output logic [3:0] lsb_bits // lower gray part width
);
   logic [1:0] lgc_code;
   logic [2:0] delta_code;
   logic [7:0] delta_base;
   assign lgc_code = low_gray_reg[ldc_pkg::LGC_LSB +: 2];
   assign delta_code = low_gray_reg[ldc_pkg::DELTA_LSB +: 3];
   assign low_gray_ns = 8'(lgc_code * ldc_pkg::LGC_STEP_NS);
   assign delta_base = 8'(delta_code * ldc_pkg::DELTA_STEP_NS);
   assign delta_ns = low_gray_reg[ldc_pkg::DELTA_HI_BIT] ?
                     8'(delta_base + ldc_pkg::DELTA_HI_NS) : delta_base;
   // Lower part is fixed at six bits; the remainder is spread over refreshes.
   assign lsb_bits = 4'h6;
   assign msb_bits = first_reg[ldc_pkg::GRAY13_BIT] ? 4'h7 : 4'h8;
endmodule // ldc_timing_decode
`default_nettype wire

// ===== dv/ldc_config_regs_properties.sv
`timescale 1ns/1ps
`default_nettype none
module ldc_config_regs_properties (
   input wire logic clk, // clock
   input wire logic rst_n, // reset, active low
   input wire logic [2:0] addr, // register index
   input wire logic [15:0] wdata, // write data
   input wire logic wr, // write strobe
   input wire logic rd, // read strobe
   input wire logic [15:0] rdata, // read data
   input wire logic [15:0] gray_word, // received word
   input wire logic [13:0] gray_value, // gray value
   input wire logic gray_word_error, // padding error
   input wire ldc_pkg::ldc_ctrl_t ctrl, // decoded controls
   input wire logic driver_reset // reset pulse
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Writes that pulse the driver reset are kept out of the decode checks.
   wire logic lg_wr = wr && addr == ldc_pkg::ADDR_LOW_GRAY;
   AST_LGC: assert property (lg_wr && !wdata[0] |-> ##2
      ctrl.low_gray_ns == {5'h0, $past(wdata[6:5], 2), 1'b0}) else $error("low-gray time wrong");
   AST_DELTA: assert property (lg_wr && !wdata[0] |-> ##2 ctrl.delta_ns ==
      8'($past(wdata[3:1], 2)) * 8'h0a + ($past(wdata[4], 2) ? 8'h50 : 8'h00))
      else $error("delta time wrong");
   AST_SCAN: assert property (wr && addr == ldc_pkg::ADDR_FIRST |-> ##2
      ctrl.scan_lines == $past(wdata[12:8], 2) && ctrl.gray13 == $past(wdata[7], 2)
      && ctrl.multiplier_en == $past(wdata[6], 2)) else $error("first register decode wrong");
   AST_HWRST: assert property (lg_wr && wdata[0] |=> driver_reset [*2] ##1 !driver_reset)
      else $error("driver reset pulse wrong");
   AST_HWRST_CAUSE: assert property ($rose(driver_reset) |-> $past(lg_wr && wdata[0]))
      else $error("driver reset without cause");
   AST_RDBACK: assert property (lg_wr && !wdata[0] ##1 rd && addr == ldc_pkg::ADDR_LOW_GRAY
      |=> rdata == $past(wdata, 2)) else $error("second register readback wrong");
   AST_DETECT: assert property (wr && addr == ldc_pkg::ADDR_DETECT ##1 rd
      && addr == ldc_pkg::ADDR_DETECT |=> rdata == ($past(wdata, 2) & ldc_pkg::MASK_DETECT))
      else $error("fifth register readback wrong");
   AST_GRAYERR: assert property ((gray_word[1:0] != 2'h0 && !ctrl.gray13) ##1 !ctrl.gray13
      |-> gray_word_error) else $error("padding error missed");
   AST_GRAYVAL: assert property (!ctrl.gray13 ##1 !ctrl.gray13
      |-> gray_value == $past(gray_word[15:2])) else $error("14-bit gray value wrong");
endmodule // ldc_config_regs_properties
`default_nettype wire

// ===== dv/ldc_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module ldc_ctrl_model (
   input wire logic sdi_level, // wanted serial input level
   input wire logic [13:0] value, // gray value to send
   input wire logic bad_pad, // spoils the zero padding on purpose
   output logic serial_data_input, // serial input pin
   output logic [15:0] gray_word // 16-bit gray word
);
   // The value sits in the upper bits so a 14-bit code keeps its weight.
   assign gray_word = {value, 1'b0, bad_pad};
   assign serial_data_input = sdi_level;
endmodule // ldc_ctrl_model
`default_nettype wire

// ===== dv/ldc_config_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module ldc_config_regs_tb_top;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [2:0] addr = 3'h0;
   logic [15:0] wdata = 16'h0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic sdi_level = 1'b0;
   logic [13:0] value = 14'h0000;
   logic bad_pad = 1'b0;
   logic serial_data_input, gray_word_error, driver_reset;
   logic [15:0] gray_word, rdata;
   logic [13:0] gray_value;
   ldc_pkg::ldc_ctrl_t ctrl;
   int num_errors = 0;
   int samples_checked = 0;
   logic [15:0] rst_tab [6] = '{16'h033f, 16'h0000, 16'h7fff, 16'h7fff, 16'h001f, 16'h0000};
   initial forever #50 clk = ~clk;
   ldc_ctrl_model partner (.sdi_level(sdi_level), .value(value), .bad_pad(bad_pad),
      .serial_data_input(serial_data_input), .gray_word(gray_word));
   ldc_config_regs dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .serial_data_input(serial_data_input), .gray_word(gray_word),
      .gray_value(gray_value), .gray_word_error(gray_word_error), .ctrl(ctrl),
      .driver_reset(driver_reset));
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic bus(input logic w, input logic r, input logic [2:0] a, input logic [15:0] d);
      wr <= w;
      rd <= r;
      addr <= a;
      wdata <= d;
      @(posedge clk);
   endtask
   task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
      bus(1'b1, 1'b0, a, d);
      bus(1'b0, 1'b0, a, d);
   endtask
   // Read data stand for one cycle only, so they are taken at the edge that closes that cycle.
   task automatic rd_chk(input logic [2:0] a, input logic [15:0] e);
      bus(1'b0, 1'b1, a, 16'h0000);
      bus(1'b0, 1'b0, a, 16'h0000);
      check(rdata, e);
   endtask
   task automatic wr_rd(input logic [2:0] a, input logic [15:0] d, input logic [15:0] e);
      bus(1'b1, 1'b0, a, d);
      rd_chk(a, e);
   endtask
   task automatic settle;
      repeat (4) @(posedge clk);
   endtask
   task automatic wrap_up;
      $display("errors %0d comparisons %0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      #2000000;
      num_errors++;
      wrap_up();
   end
   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      for (int i = 0; i < 6; i++) rd_chk(3'(i), rst_tab[i]);
      rd_chk(3'h7, 16'h0000);
      check(16'({ctrl.scan_lines, ctrl.memclk_en, ctrl.msb_bits}), 16'h0078);
      value <= 14'h1234;
      settle();
      check(16'({gray_word_error, gray_value}), 16'h1234);
      bad_pad <= 1'b1;
      settle();
      check(16'(gray_word_error), 16'h0001);
      bad_pad <= 1'b0;
      for (int i = 0; i < 16; i++) begin
         wr_rd(ldc_pkg::ADDR_LOW_GRAY, 16'((i % 4) * 32 + i * 2), 16'((i % 4) * 32 + i * 2));
         settle();
         check(16'(ctrl.low_gray_ns), 16'((i % 4) * 2));
         check(16'(ctrl.delta_ns), 16'((i % 8) * 10 + (i / 8) * 80));
      end
      wr_reg(ldc_pkg::ADDR_LOW_GRAY, 16'h0001);
      check(16'(driver_reset), 16'h0001);
      rd_chk(ldc_pkg::ADDR_LOW_GRAY, 16'h0000);
      wr_reg(ldc_pkg::ADDR_FIRST, 16'h1fc0);
      settle();
      check(16'({ctrl.scan_lines, ctrl.gray13, ctrl.multiplier_en}), 16'h007f);
      check(16'({ctrl.msb_bits, ctrl.lsb_bits}), 16'h0076);
      check(16'(gray_value), 16'h091a);
      wr_reg(ldc_pkg::ADDR_FIRST, 16'h0000);
      settle();
      check(16'({ctrl.scan_lines, ctrl.gray13, ctrl.multiplier_en}), 16'h0000);
      wr_reg(ldc_pkg::ADDR_DARK, 16'h8421);
      wr_reg(ldc_pkg::ADDR_DISP, 16'h7bde);
      wr_rd(ldc_pkg::ADDR_DETECT, 16'hf0f5, 16'h80f5);
      settle();
      check(16'(ctrl.comp), 16'h8421);
      check(16'({ctrl.open_thresh, ctrl.dead_level}), 16'h00e0);
      sdi_level <= 1'b1;
      settle();
      check(16'(ctrl.comp), 16'h7bde);
      check(16'({ctrl.open_thresh, ctrl.dead_level}), 16'h00f5);
      wr_rd(ldc_pkg::ADDR_MEMCLK, 16'hffff, 16'h0001);
      settle();
      check(16'(ctrl.memclk_en), 16'h0000);
      wr_reg(ldc_pkg::ADDR_DETECT, 16'h00f5);
      settle();
      check(16'(ctrl.memclk_en), 16'h0001);
      rd_chk(ldc_pkg::ADDR_STATUS, 16'h0003);
      wrap_up();
   end
endmodule // ldc_config_regs_tb_top
bind ldc_config_regs ldc_config_regs_properties props (.clk(clk), .rst_n(rst_n), .addr(addr),
   .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .gray_word(gray_word),
   .gray_value(gray_value), .gray_word_error(gray_word_error), .ctrl(ctrl),
   .driver_reset(driver_reset));
`default_nettype wire
